// ===== hw/csts_cfg.svh
// constants for the control signal timers and selectors
// Overview of operation
// - two select bits pick parameter set: 00 one, 10 two, 11 three, 01 four
// - active parameter set index is readable as state
// - default preset routes input four through timer one into set select one
// - zero delay and zero duration pass input straight to output in modes one to three, inverted in eleven to thirteen
// - two select bits pick one of four fixed frequencies, same mapping
// - two select bits pick one of four fixed percentages, same mapping
// - ramp holds when neither up nor down asserted
// - up alone rises at ramp rate, down alone falls at ramp rate
// - up and down together reset ramp to initial value
// - timer mode zero holds output inactive
// - mode one: edge starts delay, then output for duration
// - mode two: edge during delay restarts delay
// - mode three: retrigger delay, output drops when input goes inactive
// - modes eleven to thirteen trigger on falling edge
// - plus 100 counts minutes, plus 200 hours, base seconds
// - per timer delay and duration, 0 to 650.00 in hundredths, default zero
// - timer input from selectable source; defaults input four and signal one
// - timer outputs fixed; timer two always drives digital output one
`ifndef CSTS_CFG_SVH
`define CSTS_CFG_SVH
`define CSTS_A_T1MODE   12'h000
`define CSTS_A_T1DLY    12'h004
`define CSTS_A_T1DUR    12'h008
`define CSTS_A_T2MODE   12'h00c
`define CSTS_A_T2DLY    12'h010
`define CSTS_A_T2DUR    12'h014
`define CSTS_A_SRC      12'h018
`define CSTS_A_RAMP     12'h01c
`define CSTS_A_STATUS   12'h020
`define CSTS_A_RAMPVAL  12'h024
`define CSTS_TIME_MAX   16'd65000
`define CSTS_SRC_RST    8'h83
`define CSTS_MODE_RST   8'h01
`define CSTS_OUT_RST    4'h5
`define CSTS_CLK_HZ     250000000
`define CSTS_HUND_SEC   100
`define CSTS_MIN_MULT   60
`define CSTS_HOUR_MULT  3600
`define CSTS_RAMP_STEP  16'h0001
`define CSTS_RAMP_INIT  16'h0000
`define CSTS_RAMP_MAX   16'hffff
`endif

// ===== hw/csts_pkg.sv
// types for the control signal timers and selectors
package csts_pkg;
    typedef enum logic [1:0] {CSTS_IDLE, CSTS_DELAY, CSTS_PULSE} csts_state_t;
    typedef enum logic [1:0] {CSTS_SEC, CSTS_MIN, CSTS_HOUR} csts_unit_t;
endpackage

// ===== hw/csts_top.sv
// signal timers, set selectors and ramp generator with apb registers
`timescale 1ns/100ps
`include "csts_cfg.svh"
module csts_top
#(
    parameter int CLK_HZ = `CSTS_CLK_HZ
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  dig_in,
    input  wire logic [3:0]  int_sig,
    input  wire logic        set_sel2,
    input  wire logic [1:0]  freq_sel,
    input  wire logic [1:0]  pct_sel,
    input  wire logic        ramp_up,
    input  wire logic        ramp_down,
    output logic             param_set_one,
    output logic             param_set_two,
    output logic             param_set_three,
    output logic             param_set_four,
    output logic [1:0]       active_set,
    output logic [1:0]       freq_idx,
    output logic [1:0]       pct_idx,
    output logic [15:0]      ramp_value,
    output logic             dig_out_one,
    output logic [1:0]       timer_out
);
    import csts_pkg::*;

    localparam int TICK_DIV = CLK_HZ / `CSTS_HUND_SEC;

    logic [7:0]  mode_r [2];
    logic [15:0] dly_r  [2];
    logic [15:0] dur_r  [2];
    logic [7:0]  src_r;
    logic [15:0] rate_r;
    logic [11:0] ext_s1, ext_s2;
    logic [2:0]  set_s1, set_s2;
    logic [1:0]  fr_s1, fr_s2, pc_s1, pc_s2;
    logic [1:0]  tin, tin_d, tout;
    logic [31:0] pre_r;
    logic        tick_sec;
    logic [11:0] mcnt_r;
    logic        tick_min, tick_hour;
    logic        acc;
    logic [15:0] rdiv_r;

    assign acc = psel && penable;

    // apb: zero wait, writes take effect at access edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // default times zero
            // default mode one, source 0x83, ramp rate one
            mode_r[0] <= `CSTS_MODE_RST;
            mode_r[1] <= `CSTS_MODE_RST;
            dly_r[0]  <= 16'h0000;
            dly_r[1]  <= 16'h0000;
            dur_r[0]  <= 16'h0000;
            dur_r[1]  <= 16'h0000;
            src_r     <= `CSTS_SRC_RST;
            rate_r    <= `CSTS_RAMP_STEP;
        end
        else if (acc && pwrite)
        begin
            unique case (paddr)
                `CSTS_A_T1MODE: mode_r[0] <= pwdata[7:0];
                `CSTS_A_T1DLY:  dly_r[0] <= (pwdata[15:0] > `CSTS_TIME_MAX) ?
                                    `CSTS_TIME_MAX : pwdata[15:0];
                `CSTS_A_T1DUR:  dur_r[0] <= (pwdata[15:0] > `CSTS_TIME_MAX) ?
                                    `CSTS_TIME_MAX : pwdata[15:0];
                `CSTS_A_T2MODE: mode_r[1] <= pwdata[7:0];
                `CSTS_A_T2DLY:  dly_r[1] <= (pwdata[15:0] > `CSTS_TIME_MAX) ?
                                    `CSTS_TIME_MAX : pwdata[15:0];
                `CSTS_A_T2DUR:  dur_r[1] <= (pwdata[15:0] > `CSTS_TIME_MAX) ?
                                    `CSTS_TIME_MAX : pwdata[15:0];
                `CSTS_A_SRC:    src_r <= pwdata[7:0];
                `CSTS_A_RAMP:   rate_r <= pwdata[15:0];
                default:        ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                pslverr <= !(paddr <= `CSTS_A_RAMPVAL && paddr[1:0] == 2'b00);
                if (!pwrite)
                begin
                    unique case (paddr)
                        `CSTS_A_T1MODE:  prdata <= {24'h0, mode_r[0]};
                        `CSTS_A_T1DLY:   prdata <= {16'h0, dly_r[0]};
                        `CSTS_A_T1DUR:   prdata <= {16'h0, dur_r[0]};
                        `CSTS_A_T2MODE:  prdata <= {24'h0, mode_r[1]};
                        `CSTS_A_T2DLY:   prdata <= {16'h0, dly_r[1]};
                        `CSTS_A_T2DUR:   prdata <= {16'h0, dur_r[1]};
                        `CSTS_A_SRC:     prdata <= {24'h0, src_r};
                        `CSTS_A_RAMP:    prdata <= {16'h0, rate_r};
                        `CSTS_A_STATUS:  prdata <= {24'h0, tout, pct_idx, freq_idx,
                                                    active_set};
                        `CSTS_A_RAMPVAL: prdata <= {16'h0, ramp_value};
                        default:         prdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // pin synchronisers
    // input sync
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ext_s1 <= 12'h000;
            ext_s2 <= 12'h000;
            set_s1 <= 3'h0;
            set_s2 <= 3'h0;
            fr_s1  <= 2'h0;
            fr_s2  <= 2'h0;
            pc_s1  <= 2'h0;
            pc_s2  <= 2'h0;
        end
        else
        begin
            ext_s1 <= {int_sig, dig_in};
            ext_s2 <= ext_s1;
            set_s1 <= {ramp_down, ramp_up, set_sel2};
            set_s2 <= set_s1;
            fr_s1  <= freq_sel;
            fr_s2  <= fr_s1;
            pc_s1  <= pct_sel;
            pc_s2  <= pc_s1;
        end
    end

    // source select, 4 bits per timer over 12 sources
    // source mux
    always_comb
    begin
        tin[0] = ext_s2[src_r[3:0]];
        tin[1] = ext_s2[src_r[7:4]];
    end

    // hundredth tick prescaler
    // hundredth tick
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pre_r    <= 32'h0;
            tick_sec <= 1'b0;
            mcnt_r   <= 12'h000;
        end
        else
        begin
            tick_sec <= 1'b0;
            if (pre_r >= 32'(TICK_DIV - 1))
            begin
                pre_r    <= 32'h0;
                tick_sec <= 1'b1;
                mcnt_r   <= (mcnt_r >= 12'(`CSTS_HOUR_MULT - 1)) ? 12'h000
                            : mcnt_r + 12'h001;
            end
            else
            begin
                pre_r <= pre_r + 32'h1;
            end
        end
    end

    assign tick_min  = tick_sec && (mcnt_r % 12'(`CSTS_MIN_MULT) == 12'h000);
    assign tick_hour = tick_sec && (mcnt_r == 12'h000);

    for (genvar g = 0; g < 2; g++)
    begin : g_tmr
        csts_state_t st_r;
        logic [15:0] cnt_r;
        logic [7:0]  base;
        logic [1:0]  kind;
        logic        fall, trig, tk, act;

        always_comb
        begin
            base = mode_r[g] % 8'd100;
            kind = 2'(base % 8'd10);
            fall = base >= 8'd11 && base <= 8'd13;
            act  = (base >= 8'd1 && base <= 8'd3) || fall;
            trig = fall ? (tin_d[g] && !tin[g]) : (!tin_d[g] && tin[g]);
            unique case (mode_r[g] / 8'd100)
                8'd1:    tk = tick_min;
                8'd2:    tk = tick_hour;
                default: tk = tick_sec;
            endcase
        end

        always_ff @(posedge clk)
        begin
            if (sys_rst)
            begin
                st_r    <= CSTS_IDLE;
                cnt_r   <= 16'h0000;
                tout[g] <= 1'b0;
                tin_d[g] <= 1'b0;
            end
            else
            begin
                tin_d[g] <= tin[g];
                if (!act)
                begin
                    st_r    <= CSTS_IDLE;
                    tout[g] <= 1'b0;
                end
                else if (dly_r[g] == 16'h0000 && dur_r[g] == 16'h0000)
                begin
                    st_r    <= CSTS_IDLE;
                    tout[g] <= fall ? !tin[g] : tin[g];
                end
                else
                begin
                    unique case (st_r)
                        CSTS_IDLE:
                        begin
                            tout[g] <= 1'b0;
                            if (trig)
                            begin
                                st_r  <= CSTS_DELAY;
                                cnt_r <= 16'h0000;
                            end
                        end
                        CSTS_DELAY:
                        begin
                            if (trig && kind != 2'd1)
                                cnt_r <= 16'h0000;
                            else if (cnt_r >= dly_r[g])
                            begin
                                st_r    <= CSTS_PULSE;
                                cnt_r   <= 16'h0000;
                                tout[g] <= dur_r[g] != 16'h0000;
                            end
                            else if (tk)
                                cnt_r <= cnt_r + 16'h0001;
                        end
                        CSTS_PULSE:
                        begin
                            if (kind == 2'd3 && (fall ? tin[g] : !tin[g]))
                            begin
                                st_r    <= CSTS_IDLE;
                                tout[g] <= 1'b0;
                            end
                            else if (cnt_r >= dur_r[g])
                            begin
                                st_r    <= CSTS_IDLE;
                                tout[g] <= 1'b0;
                            end
                            else if (tk)
                                cnt_r <= cnt_r + 16'h0001;
                        end
                    endcase
                end
            end
        end
    end

    // selectors and routing
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            active_set      <= 2'd0;
            param_set_one   <= 1'b1;
            param_set_two   <= 1'b0;
            param_set_three <= 1'b0;
            param_set_four  <= 1'b0;
            freq_idx        <= 2'd0;
            pct_idx         <= 2'd0;
            dig_out_one     <= 1'b0;
            timer_out       <= 2'b00;
        end
        else
        begin
            unique case ({tout[0], set_s2[0]})
                2'b00:   active_set <= 2'd0;
                2'b10:   active_set <= 2'd1;
                2'b11:   active_set <= 2'd2;
                default: active_set <= 2'd3;
            endcase
            param_set_one   <= {tout[0], set_s2[0]} == 2'b00;
            param_set_two   <= {tout[0], set_s2[0]} == 2'b10;
            param_set_three <= {tout[0], set_s2[0]} == 2'b11;
            param_set_four  <= {tout[0], set_s2[0]} == 2'b01;
            freq_idx <= fr_s2[0] ? (fr_s2[1] ? 2'd2 : 2'd1) : (fr_s2[1] ? 2'd3 : 2'd0);
            pct_idx  <= pc_s2[0] ? (pc_s2[1] ? 2'd2 : 2'd1) : (pc_s2[1] ? 2'd3 : 2'd0);
            dig_out_one <= tout[1];
            timer_out   <= tout;
        end
    end

    // ramp generator, one step per rate_r hundredth ticks
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ramp_value <= `CSTS_RAMP_INIT;
            rdiv_r     <= 16'h0000;
        end
        else
        begin
            unique case (set_s2[2:1])
                2'b11:
                begin
                    ramp_value <= `CSTS_RAMP_INIT;
                    rdiv_r     <= 16'h0000;
                end
                2'b00: rdiv_r <= 16'h0000;
                default:
                begin
                    if (tick_sec)
                    begin
                        if (rdiv_r + 16'h0001 >= rate_r)
                        begin
                            rdiv_r <= 16'h0000;
                            if (set_s2[1] && ramp_value != `CSTS_RAMP_MAX)
                                ramp_value <= ramp_value + 16'h0001;
                            else if (set_s2[2] && ramp_value != `CSTS_RAMP_INIT)
                                ramp_value <= ramp_value - 16'h0001;
                        end
                        else
                            rdiv_r <= rdiv_r + 16'h0001;
                    end
                end
            endcase
        end
    end
endmodule

// ===== dv/csts_src_model.sv
// signal source model: contacts and logic signals
`timescale 1ns/100ps
module csts_src_model
(
    input  wire logic        clk,
    input  wire logic [18:0] req,
    output logic      [7:0]  dig_in,
    output logic      [3:0]  int_sig,
    output logic             set_sel2,
    output logic      [1:0]  freq_sel,
    output logic      [1:0]  pct_sel,
    output logic             ramp_up,
    output logic             ramp_down
);
    // contacts open at power up
    initial
        {ramp_down, ramp_up, pct_sel, freq_sel, set_sel2, int_sig, dig_in} = '0;
    // levels switch on a clock edge and hold
    always @(posedge clk)
        {ramp_down, ramp_up, pct_sel, freq_sel, set_sel2, int_sig, dig_in} <= req;
endmodule

// ===== dv/csts_top_sva.sv
// assertion checker for the timers and selectors block
`timescale 1ns/100ps
module csts_top_sva
#(
    parameter int CLK_HZ = 250000000
)
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  freq_sel,
    input wire logic [1:0]  pct_sel,
    input wire logic        ramp_up,
    input wire logic        ramp_down,
    input wire logic        set_sel2,
    input wire logic        param_set_one,
    input wire logic        param_set_two,
    input wire logic        param_set_three,
    input wire logic        param_set_four,
    input wire logic [1:0]  active_set,
    input wire logic [1:0]  freq_idx,
    input wire logic [1:0]  pct_idx,
    input wire logic [15:0] ramp_value,
    input wire logic        dig_out_one,
    input wire logic [1:0]  timer_out
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    function automatic logic [1:0] map2(input logic [1:0] s);
        map2 = {s[1], s[1] ^ s[0]};
    endfunction
    set_onehot_a: assert property ($onehot({param_set_four, param_set_three, param_set_two,
        param_set_one}))
        else $error("set outputs not one-hot");
    set_index_a: assert property ({param_set_four, param_set_three, param_set_two,
        param_set_one} == (4'h1 << active_set))
        else $error("set index disagrees with set outputs");
    set_map_a: assert property ($stable(set_sel2)[*4] |->
        active_set == map2({set_sel2, timer_out[0]}))
        else $error("set choice wrong");
    freq_map_a: assert property ($stable(freq_sel)[*6] |-> freq_idx == map2(freq_sel))
        else $error("frequency choice wrong");
    pct_map_a: assert property ($stable(pct_sel)[*6] |-> pct_idx == map2(pct_sel))
        else $error("percentage choice wrong");
    ramp_hold_a: assert property ((!ramp_up && !ramp_down)[*5] |=> $stable(ramp_value))
        else $error("ramp moved while idle");
    ramp_rise_a: assert property ((ramp_up && !ramp_down)[*5] |=> ramp_value >= $past(ramp_value))
        else $error("ramp fell while rising");
    ramp_fall_a: assert property ((!ramp_up && ramp_down)[*5] |=> ramp_value <= $past(ramp_value))
        else $error("ramp rose while falling");
    ramp_reset_a: assert property ((ramp_up && ramp_down)[*5] |=> ramp_value == 16'h0000)
        else $error("ramp not returned to start");
    out_route_a: assert property (dig_out_one == timer_out[1])
        else $error("output one not following timer two");
    ready_setup_a: assert property (psel && !penable |=> pready && penable)
        else $error("no ready in access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind csts_top csts_top_sva #(.CLK_HZ(CLK_HZ)) u_csts_top_sva (.*);

// ===== dv/csts_top_tb_top.sv
// self-checking bench for the timers and selectors block
`timescale 1ns/100ps
`include "csts_cfg.svh"
module csts_top_tb_top;
    import csts_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [18:0] req;
    logic [7:0]  dig_in;
    logic [3:0]  int_sig;
    logic        set_sel2;
    logic [1:0]  freq_sel;
    logic [1:0]  pct_sel;
    logic        ramp_up;
    logic        ramp_down;
    logic        param_set_one;
    logic        param_set_two;
    logic        param_set_three;
    logic        param_set_four;
    logic [1:0]  active_set;
    logic [1:0]  freq_idx;
    logic [1:0]  pct_idx;
    logic [15:0] ramp_value;
    logic        dig_out_one;
    logic [1:0]  timer_out;
    logic [31:0] rd;
    logic        er;
    int          fails;
    int          checks_done;
    int          cyc;
    csts_top #(.CLK_HZ(400)) u_csts_top (.*);
    csts_src_model u_csts_src_model (.*);
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fails++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
        checks_done++;
        if ($isunknown(g) || g < lo || g > hi)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h..%h", $time, g, lo, hi);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cfg(input logic [31:0] m, input logic [31:0] d, input logic [31:0] w);
        apb(1'b1, `CSTS_A_T1MODE, m);
        apb(1'b1, `CSTS_A_T1DLY, d);
        apb(1'b1, `CSTS_A_T1DUR, w);
    endtask
    task automatic pulse(output int d, output int w);
        d = 0;
        w = 0;
        while (timer_out[0] !== 1'b1)
        begin
            d++;
            @(posedge clk);
        end
        while (timer_out[0] === 1'b1)
        begin
            w++;
            @(posedge clk);
        end
    endtask
    task automatic highs(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(posedge clk);
            if (timer_out[0] === 1'b1)
                h++;
        end
    endtask
    task automatic t_regs;
        chk(ramp_value, `CSTS_RAMP_INIT);
        apb(1'b0, `CSTS_A_T2DUR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `CSTS_A_SRC, 32'h0);
        chk(rd, 32'h83);
        apb(1'b1, `CSTS_A_T1DLY, 32'hffff);
        apb(1'b0, `CSTS_A_T1DLY, 32'h0);
        chk(rd, `CSTS_TIME_MAX);
        apb(1'b0, 12'h100, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, `CSTS_A_T1DLY, 32'h0);
    endtask
    task automatic t_sets;
        logic [1:0] c;
        apb(1'b1, `CSTS_A_SRC, 32'h83);
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            req[3] <= c[1] ^ c[0];
            req[12] <= c[1];
            req[14:13] <= {c[1], c[1] ^ c[0]};
            req[16:15] <= {~c[1], c[1] ^ c[0]};
            repeat (12) @(posedge clk);
            chk({param_set_four, param_set_three, param_set_two, param_set_one}, 1 << i);
            chk(active_set, i);
            chk(freq_idx, i);
            chk(pct_idx, 3 - i);
            apb(1'b0, `CSTS_A_STATUS, 32'h0);
            chk(rd[1:0], i);
        end
    endtask
    task automatic t_route;
        req[8] <= 1'b1;
        repeat (10) @(posedge clk);
        chk(dig_out_one, 1'b1);
        chk(timer_out[1], 1'b1);
        req[8] <= 1'b0;
        repeat (10) @(posedge clk);
        chk(dig_out_one, 1'b0);
    endtask
    task automatic t_ramp;
        logic [15:0] v;
        req[17] <= 1'b1;
        repeat (100) @(posedge clk);
        req[17] <= 1'b0;
        repeat (10) @(posedge clk);
        v = ramp_value;
        chk_rng(v, 21, 27);
        repeat (40) @(posedge clk);
        chk(ramp_value, v);
        req[18] <= 1'b1;
        repeat (40) @(posedge clk);
        req[18] <= 1'b0;
        repeat (10) @(posedge clk);
        chk_rng(ramp_value, v - 11, v - 9);
        req[18:17] <= 2'b11;
        repeat (10) @(posedge clk);
        chk(ramp_value, `CSTS_RAMP_INIT);
        req[18:17] <= 2'b00;
    endtask
    task automatic t_normal;
        int d;
        int w;
        cfg(0, 0, 0);
        req[3] <= 1'b1;
        highs(30, w);
        chk(w, 0);
        req[3] <= 1'b0;
        cfg(1, 2, 3);
        req[3] <= 1'b1;
        pulse(d, w);
        chk_rng(d, 8, 22);
        chk_rng(w, 7, 16);
        req[3] <= 1'b0;
    endtask
    task automatic t_retrig;
        int d;
        int w;
        cfg(2, 5, 2);
        req[3] <= 1'b1;
        repeat (6) @(posedge clk);
        req[3] <= 1'b0;
        repeat (6) @(posedge clk);
        req[3] <= 1'b1;
        pulse(d, w);
        chk_rng(d + 12, 30, 44);
        req[3] <= 1'b0;
    endtask
    task automatic t_gated;
        int d;
        int w;
        cfg(3, 1, 20);
        req[3] <= 1'b1;
        fork
            begin
                repeat (20) @(posedge clk);
                req[3] <= 1'b0;
            end
        join_none
        pulse(d, w);
        chk_rng(w, 4, 20);
    endtask
    task automatic t_fall_min;
        int d;
        int w;
        cfg(11, 1, 3);
        req[3] <= 1'b1;
        highs(30, w);
        chk(w, 0);
        req[3] <= 1'b0;
        pulse(d, w);
        chk_rng(w, 7, 16);
        cfg(101, 2, 2);
        req[3] <= 1'b1;
        pulse(d, w);
        chk_rng(d, 240, 500);
        chk_rng(w, 240, 490);
        req[3] <= 1'b0;
        cfg(201, 1, 1);
        req[3] <= 1'b1;
        pulse(d, w);
        chk_rng(w, 14398, 14402);
        req[3] <= 1'b0;
    endtask
    initial
    begin
        fails = 0;
        checks_done = 0;
        cyc = 0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, req} = '0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_sets;
        t_route;
        t_ramp;
        t_normal;
        t_retrig;
        t_gated;
        t_fall_min;
        give_verdict;
    end
endmodule
